// >>> common/tcxo_pkg.sv
// Shared constants and types for the oscillator tuning and temperature register block
package tcxo_pkg;

  // ==========================================================================
  // Command codes
  localparam logic [7:0] CMD_DIVIDER = 8'h5D;
  localparam logic [7:0] CMD_CONTROL = 8'h60;
  localparam logic [7:0] CMD_TEMP_HI = 8'h64;
  localparam logic [7:0] CMD_TEMP_LO = 8'h65;
  localparam logic [7:0] CMD_OFFSET  = 8'h66;

  // ==========================================================================
  // Reset values and fixed patterns
  localparam logic [7:0] DIVIDER_RST  = 8'h00;
  localparam logic [7:0] CONTROL_RST  = 8'h00;
  localparam logic [7:0] OFFSET_RST   = 8'h00;
  localparam logic [7:0] IDLE_BYTE    = 8'hFF;
  localparam logic [5:0] TEMP_LO_PAD  = 6'h00;
  localparam logic [3:0] BITS_IN_BYTE = 4'h8;
  localparam logic [3:0] BIT_FIRST    = 4'h1;
  localparam int unsigned TEMP_W      = 10;
  localparam int unsigned TEMP_FRAC_W = 2;
  localparam int unsigned OFFSET_SIGN = 7;

  // Slave address upper six bits; value is arbitrary
  localparam logic [5:0] SLAVE_ADDR_HI = 6'h24;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned CONV_TIME_US  = 100;
  localparam int unsigned CONV_CYCLES   = (CONV_TIME_US * 1000) / CLK_PERIOD_NS;

  // ==========================================================================
  // Serial slave states
  typedef enum logic [8:0] {
    ST_IDLE    = 9'h001,
    ST_ADDR    = 9'h002,
    ST_ADDR_AK = 9'h004,
    ST_CMD     = 9'h008,
    ST_CMD_AK  = 9'h010,
    ST_WDATA   = 9'h020,
    ST_WDAT_AK = 9'h040,
    ST_RDATA   = 9'h080,
    ST_RACK    = 9'h100
  } slave_state_t;

endpackage : tcxo_pkg

// >>> common/conv_if.sv
// Carrier between the temperature converter and the register block
`timescale 1ns/1ps
interface conv_if;
  logic                            done;
  logic [tcxo_pkg::TEMP_W-1:0]     result;
  modport src (output done, output result);
  modport snk (input done, input result);
endinterface : conv_if

// >>> hw/temp_converter.sv
// Free-running temperature conversion sequencer
`timescale 1ns/1ps
module temp_converter #(
  parameter int unsigned CONV_CYCLES = tcxo_pkg::CONV_CYCLES
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset,
  // Sensor front end
  input  wire logic [tcxo_pkg::TEMP_W-1:0] temp_raw,
  // Result towards the registers
  conv_if.src                              conv
);

  localparam int unsigned CNT_W = $clog2(CONV_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

  typedef struct packed {
    logic [CNT_W-1:0]            cnt;
    logic [tcxo_pkg::TEMP_W-1:0] raw_m;
    logic [tcxo_pkg::TEMP_W-1:0] raw_s;
    logic                        done;
    logic [tcxo_pkg::TEMP_W-1:0] result;
  } conv_state_t;

  conv_state_t st_r;
  conv_state_t st_nxt;

  // ==========================================================================
  // Conversion timing
  // The front end holds its code steady for a whole period, so a plain
  // two-stage capture of the bus is safe here.
  always_comb begin
    st_nxt       = st_r;
    st_nxt.raw_m = temp_raw;
    st_nxt.raw_s = st_r.raw_m;
    st_nxt.done  = 1'b0;
    if (st_r.cnt == CNT_LAST) begin
      st_nxt.cnt    = '0;
      st_nxt.done   = 1'b1;
      st_nxt.result = st_r.raw_s;
    end else begin
      st_nxt.cnt = st_r.cnt + CNT_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign conv.done   = st_r.done;
  assign conv.result = st_r.result;

endmodule : temp_converter

// >>> hw/tcxo_regs.sv
// Two-wire slave with tuning, control and temperature registers
`timescale 1ns/1ps
module tcxo_regs #(
  parameter int unsigned LOAD_W      = 12,
  parameter int unsigned CONV_CYCLES = tcxo_pkg::CONV_CYCLES
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset,
  // Two-wire bus pins
  input  wire logic                        scl_in,
  input  wire logic                        sda_in,
  output logic                             sda_out,
  output logic                             sda_oe_n,
  // Address strap
  input  wire logic                        addr_strap_pin,
  // Sensor and compensation inputs
  input  wire logic [tcxo_pkg::TEMP_W-1:0] temp_raw,
  input  wire logic [LOAD_W-1:0]           factory_comp,
  // Register contents towards the oscillator
  output logic [7:0]                       divider_value,
  output logic [7:0]                       control_value,
  output logic [7:0]                       offset_value,
  output logic [LOAD_W-1:0]                load_word,
  output logic                             load_update
);

  typedef struct packed {
    tcxo_pkg::slave_state_t st;
    logic                   scl_m;
    logic                   scl_s;
    logic                   scl_p;
    logic                   sda_m;
    logic                   sda_s;
    logic                   sda_p;
    logic                   strap_m;
    logic                   strap_s;
    logic [3:0]             bitcnt;
    logic [7:0]             rxsh;
    logic [7:0]             txsh;
    logic [7:0]             ptr;
    logic                   rw;
    logic                   wrote;
    logic                   rdidx;
    logic [7:0]             lo_shadow;
    logic [7:0]             divider;
    logic [7:0]             control;
    logic [7:0]             offset;
    logic [7:0]             temp_hi;
    logic [7:0]             temp_lo;
    logic [LOAD_W-1:0]      load;
    logic                   load_upd;
    logic                   sda_oe_n;
    logic                   sda_o;
  } regs_state_t;

  regs_state_t st_r;
  regs_state_t st_nxt;

  conv_if conv ();

  temp_converter #(
    .CONV_CYCLES (CONV_CYCLES)
  ) u_conv (
    .clk      (clk),
    .reset    (reset),
    .temp_raw (temp_raw),
    .conv     (conv)
  );

  // ==========================================================================
  // Helpers
  function automatic logic known_rw(input logic [7:0] code);
    known_rw = (code == tcxo_pkg::CMD_DIVIDER) || (code == tcxo_pkg::CMD_CONTROL) ||
               (code == tcxo_pkg::CMD_OFFSET);
  endfunction : known_rw

  // Byte for a given pointer; the low half of a two-byte temperature read comes
  // from a shadow taken with the high half, so the pair never tears.
  function automatic logic [7:0] read_byte(input regs_state_t s, input logic second);
    logic [7:0] b;
    b = tcxo_pkg::IDLE_BYTE;
    case (s.ptr)
      tcxo_pkg::CMD_DIVIDER: b = second ? tcxo_pkg::IDLE_BYTE : s.divider;
      tcxo_pkg::CMD_CONTROL: b = second ? tcxo_pkg::IDLE_BYTE : s.control;
      tcxo_pkg::CMD_OFFSET:  b = second ? tcxo_pkg::IDLE_BYTE : s.offset;
      tcxo_pkg::CMD_TEMP_HI: b = second ? s.lo_shadow : s.temp_hi;
      tcxo_pkg::CMD_TEMP_LO: b = second ? tcxo_pkg::IDLE_BYTE : s.temp_lo;
      default:               b = tcxo_pkg::IDLE_BYTE;
    endcase
    read_byte = b;
  endfunction : read_byte

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign scl_rise  = st_r.scl_s & ~st_r.scl_p;
  assign scl_fall  = ~st_r.scl_s & st_r.scl_p;
  assign bus_start = st_r.scl_s & st_r.scl_p & st_r.sda_p & ~st_r.sda_s;
  assign bus_stop  = st_r.scl_s & st_r.scl_p & ~st_r.sda_p & st_r.sda_s;

  // ==========================================================================
  // Next state
  always_comb begin
    logic [7:0] tx;
    tx = tcxo_pkg::IDLE_BYTE;
    st_nxt          = st_r;
    st_nxt.scl_m    = scl_in;
    st_nxt.scl_s    = st_r.scl_m;
    st_nxt.scl_p    = st_r.scl_s;
    st_nxt.sda_m    = sda_in;
    st_nxt.sda_s    = st_r.sda_m;
    st_nxt.sda_p    = st_r.sda_s;
    st_nxt.strap_m  = addr_strap_pin;
    st_nxt.strap_s  = st_r.strap_m;
    st_nxt.load_upd = 1'b0;
    st_nxt.sda_o    = 1'b0;

    // Background conversion result and update cycle, untouched by bus traffic
    if (conv.done) begin
      st_nxt.temp_hi  = conv.result[tcxo_pkg::TEMP_W-1:tcxo_pkg::TEMP_FRAC_W];
      st_nxt.temp_lo  = {conv.result[tcxo_pkg::TEMP_FRAC_W-1:0],
                         tcxo_pkg::TEMP_LO_PAD};
      // Raw two's complement sum: 7Fh pushes up most, 80h pulls down most
      st_nxt.load     = factory_comp +
                        {{(LOAD_W-8){st_r.offset[tcxo_pkg::OFFSET_SIGN]}}, st_r.offset};
      st_nxt.load_upd = 1'b1;
    end

    if (bus_stop) begin
      st_nxt.st       = tcxo_pkg::ST_IDLE;
      st_nxt.sda_oe_n = 1'b1;
    end else if (bus_start) begin
      st_nxt.st       = tcxo_pkg::ST_ADDR;
      st_nxt.bitcnt   = '0;
      st_nxt.wrote    = 1'b0;
      st_nxt.sda_oe_n = 1'b1;
    end else begin
      case (st_r.st)
        tcxo_pkg::ST_IDLE: begin
          st_nxt.sda_oe_n = 1'b1;
        end
        tcxo_pkg::ST_ADDR, tcxo_pkg::ST_CMD, tcxo_pkg::ST_WDATA: begin
          if (scl_rise && st_r.bitcnt != tcxo_pkg::BITS_IN_BYTE) begin
            st_nxt.rxsh   = {st_r.rxsh[6:0], st_r.sda_s};
            st_nxt.bitcnt = st_r.bitcnt + tcxo_pkg::BIT_FIRST;
          end else if (scl_fall && st_r.bitcnt == tcxo_pkg::BITS_IN_BYTE) begin
            st_nxt.bitcnt = '0;
            if (st_r.st == tcxo_pkg::ST_ADDR) begin
              if (st_r.rxsh[7:1] == {tcxo_pkg::SLAVE_ADDR_HI, st_r.strap_s}) begin
                st_nxt.rw       = st_r.rxsh[0];
                st_nxt.sda_oe_n = 1'b0;
                st_nxt.st       = tcxo_pkg::ST_ADDR_AK;
              end else begin
                st_nxt.st = tcxo_pkg::ST_IDLE;
              end
            end else if (st_r.st == tcxo_pkg::ST_CMD) begin
              st_nxt.ptr      = st_r.rxsh;
              st_nxt.sda_oe_n = 1'b0;
              st_nxt.st       = tcxo_pkg::ST_CMD_AK;
            end else if (!st_r.wrote && known_rw(st_r.ptr)) begin
              case (st_r.ptr)
                tcxo_pkg::CMD_DIVIDER: st_nxt.divider = st_r.rxsh;
                tcxo_pkg::CMD_CONTROL: st_nxt.control = st_r.rxsh;
                default:               st_nxt.offset  = st_r.rxsh;
              endcase
              st_nxt.wrote    = 1'b1;
              st_nxt.sda_oe_n = 1'b0;
              st_nxt.st       = tcxo_pkg::ST_WDAT_AK;
            end else begin
              // Temperature bytes, unknown codes and extra bytes are refused
              st_nxt.st = tcxo_pkg::ST_IDLE;
            end
          end
        end
        tcxo_pkg::ST_ADDR_AK: begin
          if (scl_fall) begin
            if (st_r.rw) begin
              tx                = read_byte(st_r, 1'b0);
              st_nxt.lo_shadow  = st_r.temp_lo;
              st_nxt.rdidx      = 1'b0;
              st_nxt.sda_oe_n   = tx[7];
              st_nxt.txsh       = {tx[6:0], 1'b1};
              st_nxt.bitcnt     = tcxo_pkg::BIT_FIRST;
              st_nxt.st         = tcxo_pkg::ST_RDATA;
            end else begin
              st_nxt.sda_oe_n = 1'b1;
              st_nxt.st       = tcxo_pkg::ST_CMD;
            end
          end
        end
        tcxo_pkg::ST_CMD_AK, tcxo_pkg::ST_WDAT_AK: begin
          if (scl_fall) begin
            st_nxt.sda_oe_n = 1'b1;
            st_nxt.st       = tcxo_pkg::ST_WDATA;
          end
        end
        tcxo_pkg::ST_RDATA: begin
          if (scl_fall) begin
            if (st_r.bitcnt == tcxo_pkg::BITS_IN_BYTE) begin
              st_nxt.sda_oe_n = 1'b1;
              st_nxt.st       = tcxo_pkg::ST_RACK;
            end else begin
              st_nxt.sda_oe_n = st_r.txsh[7];
              st_nxt.txsh     = {st_r.txsh[6:0], 1'b1};
              st_nxt.bitcnt   = st_r.bitcnt + tcxo_pkg::BIT_FIRST;
            end
          end
        end
        tcxo_pkg::ST_RACK: begin
          if (scl_rise && st_r.sda_s) begin
            st_nxt.st = tcxo_pkg::ST_IDLE;
          end else if (scl_fall) begin
            // Only one byte follows the first; anything later is filler
            tx              = st_r.rdidx ? tcxo_pkg::IDLE_BYTE : read_byte(st_r, 1'b1);
            st_nxt.rdidx    = 1'b1;
            st_nxt.sda_oe_n = tx[7];
            st_nxt.txsh     = {tx[6:0], 1'b1};
            st_nxt.bitcnt   = tcxo_pkg::BIT_FIRST;
            st_nxt.st       = tcxo_pkg::ST_RDATA;
          end
        end
        default: begin
          st_nxt.st       = tcxo_pkg::ST_IDLE;
          st_nxt.sda_oe_n = 1'b1;
        end
      endcase
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r          <= '0;
      st_r.st       <= tcxo_pkg::ST_IDLE;
      st_r.scl_m    <= 1'b1;
      st_r.scl_s    <= 1'b1;
      st_r.scl_p    <= 1'b1;
      st_r.sda_m    <= 1'b1;
      st_r.sda_s    <= 1'b1;
      st_r.sda_p    <= 1'b1;
      st_r.divider  <= tcxo_pkg::DIVIDER_RST;
      st_r.control  <= tcxo_pkg::CONTROL_RST;
      st_r.offset   <= tcxo_pkg::OFFSET_RST;
      st_r.sda_oe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sda_out       = st_r.sda_o;
  assign sda_oe_n      = st_r.sda_oe_n;
  assign divider_value = st_r.divider;
  assign control_value = st_r.control;
  assign offset_value  = st_r.offset;
  assign load_word     = st_r.load;
  assign load_update   = st_r.load_upd;

endmodule : tcxo_regs

// >>> verification/tcxo_regs_monitor.sv
// Port-level assertions for the tuning and temperature register block
`timescale 1ns/1ps
module tcxo_regs_monitor #(
  parameter int unsigned LOAD_W      = 12,
  parameter int unsigned CONV_CYCLES = tcxo_pkg::CONV_CYCLES
) (
  // Clock and reset
  input wire logic                        clk,
  input wire logic                        reset,
  // Bus pins and strap
  input wire logic                        scl_in,
  input wire logic                        sda_in,
  input wire logic                        sda_out,
  input wire logic                        sda_oe_n,
  input wire logic                        addr_strap_pin,
  // Sensor, compensation and register outputs
  input wire logic [tcxo_pkg::TEMP_W-1:0] temp_raw,
  input wire logic [LOAD_W-1:0]           factory_comp,
  input wire logic [7:0]                  divider_value,
  input wire logic [7:0]                  control_value,
  input wire logic [7:0]                  offset_value,
  input wire logic [LOAD_W-1:0]           load_word,
  input wire logic                        load_update
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ==========================================================================
  // Cycles since the last update; a counter avoids a huge repetition
  int unsigned gap_r;
  logic        seen_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      gap_r  <= 0;
      seen_r <= 1'b0;
    end else if (load_update) begin
      gap_r  <= 0;
      seen_r <= 1'b1;
    end else begin
      gap_r <= gap_r + 1;
    end
  end

  // ==========================================================================
  // Checks
  sequence reg_stored;
    $changed(offset_value) || $changed(divider_value) || $changed(control_value);
  endsequence
  sequence ack_driven;
    ##[0:4] !sda_oe_n;
  endsequence

  chk_reset_clears:
    assert property (disable iff (1'b0) reset |=> (offset_value == 8'h00) && sda_oe_n
      && (divider_value == 8'h00) && (control_value == 8'h00) && !load_update)
    else $error("outputs not cleared by reset");
  chk_load_sum:
    assert property (load_update |-> load_word == LOAD_W'($past(factory_comp)
      + {{(LOAD_W-8){$past(offset_value[7])}}, $past(offset_value)}))
    else $error("load word is not compensation plus offset");
  chk_update_pulse:
    assert property (load_update |=> !load_update)
    else $error("update pulse longer than one cycle");
  chk_word_on_update:
    assert property ($changed(load_word) |-> load_update)
    else $error("load word changed outside an update");
  chk_update_period:
    assert property (seen_r && load_update |-> gap_r == CONV_CYCLES - 1)
    else $error("conversion period disturbed");
  chk_update_missing:
    assert property (seen_r |-> gap_r < CONV_CYCLES)
    else $error("conversion result overdue");
  chk_store_acked:
    assert property (reg_stored |-> ack_driven)
    else $error("register stored without acknowledge");
  chk_drive_scl_low:
    assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data drive changed while bus clock high");
  chk_open_drain_low:
    assert property (sda_out == 1'b0)
    else $error("data line driven high instead of released");
endmodule : tcxo_regs_monitor

bind tcxo_regs tcxo_regs_monitor #(.LOAD_W(LOAD_W), .CONV_CYCLES(CONV_CYCLES))
  tcxo_regs_monitor_inst (.clk(clk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_strap_pin(addr_strap_pin),
  .temp_raw(temp_raw), .factory_comp(factory_comp), .divider_value(divider_value),
  .control_value(control_value), .offset_value(offset_value), .load_word(load_word),
  .load_update(load_update));

// >>> verification/twi_master.sv
// Two-wire bus master model with open-drain data line and pull-up
`timescale 1ns/1ps
module twi_master (
  // Clock
  input wire logic clk,
  // Device drive of the data line
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // Resolved bus lines
  output logic     scl,
  output logic     sda
);
  logic m_sda;
  // Pull-up wins unless either party pulls low
  assign sda = m_sda & (sda_oe_n | sda_out);
  initial begin
    scl   = 1'b1;
    m_sda = 1'b1;
  end

  // ==========================================================================
  // Bus conditions and bits
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic start();
    m_sda = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(8);
    m_sda = 1'b0;
    tick(8);
    scl = 1'b0;
    tick(4);
  endtask : start
  task automatic stop();
    m_sda = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    m_sda = 1'b1;
    tick(8);
  endtask : stop
  // Data moves only while the bus clock is low; sampled mid high phase
  task automatic put_bit(input logic b, output logic r);
    m_sda = b;
    tick(4);
    scl = 1'b1;
    tick(4);
    r = sda;
    tick(4);
    scl = 1'b0;
    tick(4);
  endtask : put_bit
  task automatic send_byte(input logic [7:0] b, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) put_bit(b[i], r);
    put_bit(1'b1, nack);
  endtask : send_byte
  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) put_bit(1'b1, b[i]);
    put_bit(last, r);
  endtask : recv_byte
endmodule : twi_master

// >>> verification/tb.sv
// Self-checking bench for the tuning and temperature register block
`timescale 1ns/1ps
module tb;
  logic        clk, reset, scl, sda, sda_out, sda_oe_n, strap, load_update, nack;
  logic [9:0]  temp_raw;
  logic [11:0] fact, load_word;
  logic [7:0]  divider_value, control_value, offset_value;
  logic [15:0] rd;
  int          err_count = 0;
  int          n_checks = 0;
  logic [7:0]  cmds [3] = '{tcxo_pkg::CMD_DIVIDER, tcxo_pkg::CMD_CONTROL, tcxo_pkg::CMD_OFFSET};
  logic [7:0]  o_val [4] = '{8'h7F, 8'h80, 8'hFF, 8'h00};
  logic [9:0]  t_raw [6] = '{10'h154, 10'h12C, 10'h002, 10'h3FE, 10'h3B0, 10'h360};
  logic [15:0] t_exp [6] = '{16'h5500, 16'h4B00, 16'h0080, 16'hFF80, 16'hEC00, 16'hD800};

  twi_master twi_master_inst (.clk(clk), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .scl(scl), .sda(sda));
  tcxo_regs #(.LOAD_W(12), .CONV_CYCLES(20)) tcxo_regs_inst (.clk(clk), .reset(reset),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .addr_strap_pin(strap), .temp_raw(temp_raw), .factory_comp(fact),
    .divider_value(divider_value), .control_value(control_value),
    .offset_value(offset_value), .load_word(load_word), .load_update(load_update));

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("mismatches=%0d checks=%0d", err_count, n_checks);
    if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic addr_cmd(input logic [7:0] cmd);
    twi_master_inst.start();
    twi_master_inst.send_byte({tcxo_pkg::SLAVE_ADDR_HI, strap, 1'b0}, nack);
    check(16'(nack), 16'h0000);
    twi_master_inst.send_byte(cmd, nack);
    check(16'(nack), 16'h0000);
  endtask : addr_cmd
  task automatic reg_write(input logic [7:0] cmd, input logic [7:0] data);
    addr_cmd(cmd);
    twi_master_inst.send_byte(data, nack);
    twi_master_inst.stop();
  endtask : reg_write
  task automatic reg_read(input logic [7:0] cmd, input logic two);
    addr_cmd(cmd);
    twi_master_inst.start();
    twi_master_inst.send_byte({tcxo_pkg::SLAVE_ADDR_HI, strap, 1'b1}, nack);
    check(16'(nack), 16'h0000);
    rd = 16'h0000;
    twi_master_inst.recv_byte(!two, rd[15:8]);
    if (two) twi_master_inst.recv_byte(1'b1, rd[7:0]);
    twi_master_inst.stop();
  endtask : reg_read
  task automatic wait_update();
    int i;
    for (i = 0; i < 100; i++) begin
      @(negedge clk);
      if (load_update === 1'b1) break;
    end
    if (i == 100) begin
      err_count++;
      report_and_stop();
    end
  endtask : wait_update

  // ==========================================================================
  // Clock and sequence
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    reset = 1'b1;
    strap = 1'b0;
    temp_raw = 10'h000;
    fact = 12'h800;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    foreach (cmds[k]) begin
      reg_read(cmds[k], 1'b0);
      check(rd, 16'h0000);
      reg_write(cmds[k], 8'hA5 ^ 8'(k));
      check(16'(nack), 16'h0000);
      reg_read(cmds[k], 1'b0);
      check(rd, {8'hA5 ^ 8'(k), 8'h00});
    end
    check({divider_value, control_value}, 16'hA5A4);
    foreach (o_val[k]) begin
      reg_write(tcxo_pkg::CMD_OFFSET, o_val[k]);
      check(16'(offset_value), 16'(o_val[k]));
      wait_update();
      check(16'(load_word), 16'(12'(fact + {{4{o_val[k][7]}}, o_val[k]})));
    end
    foreach (t_raw[k]) begin
      temp_raw = t_raw[k];
      wait_update();
      wait_update();
      reg_read(tcxo_pkg::CMD_TEMP_HI, 1'b1);
      check(rd, t_exp[k]);
    end
    reg_read(tcxo_pkg::CMD_TEMP_HI, 1'b0);
    check(rd, {t_exp[5][15:8], 8'h00});
    reg_write(tcxo_pkg::CMD_TEMP_HI, 8'h12);
    check(16'(nack), 16'h0001);
    reg_read(tcxo_pkg::CMD_TEMP_HI, 1'b1);
    check(rd, t_exp[5]);
    reg_read(8'h70, 1'b0);
    check(rd, 16'hFF00);
    // A third temperature byte is filler
    addr_cmd(tcxo_pkg::CMD_TEMP_HI);
    twi_master_inst.start();
    twi_master_inst.send_byte({tcxo_pkg::SLAVE_ADDR_HI, strap, 1'b1}, nack);
    twi_master_inst.recv_byte(1'b0, rd[15:8]);
    twi_master_inst.recv_byte(1'b0, rd[7:0]);
    check(rd, t_exp[5]);
    twi_master_inst.recv_byte(1'b1, rd[7:0]);
    twi_master_inst.stop();
    check(rd, {t_exp[5][15:8], 8'hFF});
    strap = 1'b1;
    repeat (4) @(negedge clk);
    reg_read(tcxo_pkg::CMD_OFFSET, 1'b0);
    check(rd, 16'h0000);
    twi_master_inst.start();
    twi_master_inst.send_byte({tcxo_pkg::SLAVE_ADDR_HI, 1'b0, 1'b0}, nack);
    check(16'(nack), 16'h0001);
    twi_master_inst.stop();
    report_and_stop();
  end
endmodule : tb
